/* File: inc/sleep_wake_defs.vh */
`ifndef SLEEP_WAKE_DEFS_VH
`define SLEEP_WAKE_DEFS_VH

// ==========================================================
// register addresses (plain port, 8-bit data)
`define ADDR_W            4
`define OFF_PORT_CHG_MASK 4'h0
`define OFF_CORE_IRQ      4'h1
`define OFF_PERIPH_EN     4'h2
`define OFF_PERIPH_FLAGS  4'h3
`define OFF_CTRL          4'h4
`define OFF_STATUS        4'h5
`define OFF_EVT_STATUS    4'h6
`define OFF_EVT_MASK      4'h7
`define OFF_WDT_COUNT     4'h8

// ==========================================================
// core_irq_control fields
`define CIC_GIE           7
`define CIC_PERIPHERAL_IRQ_ENABLE_BIT          6
`define CIC_T0IE          5
`define CIC_EXT_PIN_IRQ_ENABLE          4
`define CIC_PCIE          3
`define CIC_T0IF          2
`define CIC_INTF          1
`define CIC_PCIF          0

// ==========================================================
// peripheral_irq_enable / flags wake-capable bits
`define PIE_WAKE_MASK     8'h6d

// ==========================================================
// control register fields
`define CTRL_WDT_EN       0

// ==========================================================
// event status bits
`define EVT_SLEEP         0
`define EVT_WAKE_IRQ      1
`define EVT_WAKE_WDT      2
`define EVT_SLEEP_NOP     3

// ==========================================================
// reset values and timing
`define RST_PORT_CHG_MASK 8'h00
`define RST_CORE_IRQ      8'h00
`define RST_PERIPH        8'h00
`define RST_CTRL          8'h00
`define WDT_W             16
`define WDT_TIMEOUT       16'hffff
`define OSC_START_CYC     8'h10
`define IRQ_VECTOR        13'h0004

`endif

/* File: rtl/sleep_wake_controller.v */
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_defs.vh"

// Summary of operation
// - sleep opcode from core enters power-down.
// - entry clears watchdog count; it keeps counting while asleep.
// - entry clears powerdown_flag_n and sets timeout_flag_n.
// - oscillator driver off while asleep.
// - I/O ports keep their drive state while asleep.
// - watchdog reset never drives the external reset pin low.
// - wake on external reset, enabled watchdog, or enabled interrupt.
// - external reset does full reset; watchdog and interrupt wakes continue.
// - powerdown_flag_n set at power-up; timeout_flag_n cleared on watchdog wake.
// - only clockless-capable interrupt sources can wake.
// - next instruction prefetched during the sleep opcode.
// - wake needs source enable; global enable ignored.
// - after irq wake run prefetched instruction, then vector if global enable.
// - every wake clears the watchdog count.
// - pending enabled irq before opcode makes sleep a no-op.
// - irq during or after opcode: full sleep, then immediate wake.
module sleep_wake_controller (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire        sleep_op_i,
  input  wire [12:0] pc_i,
  input  wire        ext_pin_irq_i,
  input  wire [7:0]  port_change_i,
  input  wire [7:0]  periph_irq_i,
  input  wire        osc_ready_i,
  input  wire [7:0]  port_out_i,
  input  wire [7:0]  port_oe_i,
  output reg  [7:0]  port_out_o,
  output reg  [7:0]  port_oe_o,
  output reg         osc_drive_en_o,
  output reg         core_hold_o,
  output reg         prefetch_o,
  output reg  [12:0] prefetch_addr_o,
  output reg         vector_o,
  output reg  [12:0] vector_addr_o,
  output reg         wdt_reset_o,
  output reg         ext_reset_pin_oe_o,
  output reg         powerdown_flag_n_o,
  output reg         timeout_flag_n_o,
  output reg         irq_o
);

  // ========================================================
  // states
  localparam ST_RUN   = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_OSC   = 2'd2;
  localparam ST_POST  = 2'd3;

  reg [1:0]        state_q;
  reg [7:0]        port_chg_mask_q;
  reg [7:0]        core_irq_q;
  reg [7:0]        periph_en_q;
  reg [7:0]        periph_flags_q;
  reg [7:0]        ctrl_q;
  reg [3:0]        evt_q;
  reg [3:0]        evt_mask_q;
  reg [`WDT_W-1:0] wdt_q;
  reg [7:0]        osc_cnt_q;
  reg [7:0]        port_prev_q;
  reg              wake_irq_q;
  reg              vec_pend_q;

  wire             wdt_en;
  wire             wdt_to;
  wire [7:0]       port_chg;
  wire [7:0]       periph_set;
  wire [7:0]       wake_vec;
  wire             irq_pend;
  wire             do_sleep;
  wire             do_nop;
  reg  [3:0]       evt_set;

  assign wdt_en     = ctrl_q[`CTRL_WDT_EN];
  assign wdt_to     = wdt_en && (wdt_q == `WDT_TIMEOUT);
  wire [7:0]       periph_hit;
  genvar           gi;
  // per-pin change detect and per-source pending, masked bits never count
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      assign port_chg[gi]   = (port_change_i[gi] ^ port_prev_q[gi]) & port_chg_mask_q[gi];
      assign periph_hit[gi] = periph_en_q[gi] & periph_flags_q[gi];
    end
  endgenerate
  // other sources need a clock, so masked off while asleep
  assign periph_set = periph_irq_i & ((state_q == ST_SLEEP) ? `PIE_WAKE_MASK : 8'hff);
  // global enable deliberately absent from this term
  assign wake_vec[0] = core_irq_q[`CIC_EXT_PIN_IRQ_ENABLE] & core_irq_q[`CIC_INTF];
  assign wake_vec[1] = core_irq_q[`CIC_PCIE] & core_irq_q[`CIC_PCIF];
  assign wake_vec[2] = core_irq_q[`CIC_PERIPHERAL_IRQ_ENABLE_BIT] & (|periph_hit);
  assign wake_vec[7:3] = 5'h00;
  assign irq_pend = |wake_vec;
  // flag already pending before opcode: no-op
  assign do_nop   = sleep_op_i && (state_q == ST_RUN) && irq_pend;
  assign do_sleep = sleep_op_i && (state_q == ST_RUN) && !irq_pend;

  // ========================================================
  // register port decode
  wire             wr_core_irq;
  wire             wr_periph_flags;
  wire             rd_evt;
  wire             wake_go;
  wire             run_tmo;
  wire [3:0]       evt_d;
  reg  [7:0]       rdata_d;

  assign wr_core_irq     = reg_wr_i && (reg_addr_i == `OFF_CORE_IRQ);
  assign wr_periph_flags = reg_wr_i && (reg_addr_i == `OFF_PERIPH_FLAGS);
  assign rd_evt          = reg_rd_i && (reg_addr_i == `OFF_EVT_STATUS);
  // read clears, but a same-cycle event stays set
  assign evt_d           = (rd_evt ? 4'h0 : evt_q) | evt_set;
  assign wake_go         = (state_q == ST_SLEEP) && (irq_pend || wdt_to);
  assign run_tmo         = (state_q == ST_RUN) && !sleep_op_i && wdt_to;

  // ========================================================
  // plain control registers
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_chg_mask_q <= `RST_PORT_CHG_MASK;
    end else if (reg_wr_i && reg_addr_i == `OFF_PORT_CHG_MASK) begin
      // low four pins have no change detector
      port_chg_mask_q <= {reg_wdata_i[7:4], 4'h0};
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_en_q <= `RST_PERIPH;
    end else if (reg_wr_i && reg_addr_i == `OFF_PERIPH_EN) begin
      periph_en_q <= reg_wdata_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `RST_CTRL;
    end else if (reg_wr_i && reg_addr_i == `OFF_CTRL) begin
      ctrl_q <= reg_wdata_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_mask_q <= 4'h0;
    end else if (reg_wr_i && reg_addr_i == `OFF_EVT_MASK) begin
      evt_mask_q <= reg_wdata_i[3:0];
    end
  end

  // ========================================================
  // interrupt flags
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_prev_q <= 8'h00;
    end else begin
      port_prev_q <= port_change_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_irq_q <= `RST_CORE_IRQ;
    end else begin
      if (wr_core_irq)
        core_irq_q <= reg_wdata_i;
      // hardware sets win over software writes
      core_irq_q[`CIC_INTF] <= (wr_core_irq ? reg_wdata_i[`CIC_INTF] : core_irq_q[`CIC_INTF])
                               | ext_pin_irq_i;
      core_irq_q[`CIC_PCIF] <= (wr_core_irq ? reg_wdata_i[`CIC_PCIF] : core_irq_q[`CIC_PCIF])
                               | (|port_chg);
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_flags_q <= `RST_PERIPH;
    end else begin
      periph_flags_q <= (wr_periph_flags ? reg_wdata_i : periph_flags_q) | periph_set;
    end
  end

  // ========================================================
  // event status and interrupt line
  always @* begin
    evt_set = 4'h0;
    evt_set[`EVT_SLEEP]     = do_sleep;
    evt_set[`EVT_SLEEP_NOP] = do_nop;
    evt_set[`EVT_WAKE_IRQ]  = (state_q == ST_SLEEP) && irq_pend;
    evt_set[`EVT_WAKE_WDT]  = (state_q == ST_SLEEP) && wdt_to && !irq_pend;
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_q <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      evt_q <= evt_d;
      irq_o <= |(evt_d & evt_mask_q);
    end
  end

  // ========================================================
  // power-down status flags
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      powerdown_flag_n_o <= 1'b1;
      timeout_flag_n_o   <= 1'b1;
    end else begin
      if (do_sleep) begin
        powerdown_flag_n_o <= 1'b0;
        timeout_flag_n_o   <= 1'b1;
      end
      // irq has priority, so a joint wake reads as an irq wake
      if (state_q == ST_SLEEP && wdt_to && !irq_pend)
        timeout_flag_n_o <= 1'b0;
    end
  end

  // ========================================================
  // read port
  always @* begin
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `OFF_PORT_CHG_MASK: rdata_d = port_chg_mask_q;
        `OFF_CORE_IRQ:      rdata_d = core_irq_q;
        `OFF_PERIPH_EN:     rdata_d = periph_en_q;
        `OFF_PERIPH_FLAGS:  rdata_d = periph_flags_q;
        `OFF_CTRL:          rdata_d = ctrl_q;
        `OFF_STATUS:        rdata_d = {4'h0, state_q == ST_SLEEP, wdt_en,
                                       timeout_flag_n_o, powerdown_flag_n_o};
        `OFF_EVT_STATUS:    rdata_d = {4'h0, evt_q};
        `OFF_EVT_MASK:      rdata_d = {4'h0, evt_mask_q};
        `OFF_WDT_COUNT:     rdata_d = wdt_q[7:0];
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end

  // ========================================================
  // port drive hold
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_out_o <= 8'h00;
      port_oe_o  <= 8'h00;
    end else if (state_q != ST_SLEEP) begin
      // frozen pads cost one cycle of latency while awake
      port_out_o <= port_out_i;
      port_oe_o  <= port_oe_i;
    end
  end

  // ========================================================
  // watchdog counter
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_q <= {`WDT_W{1'b0}};
    end else if (do_sleep) begin
      wdt_q <= {`WDT_W{1'b0}};
    end else if (wake_go || run_tmo) begin
      wdt_q <= {`WDT_W{1'b0}};
    end else if (wdt_en) begin
      wdt_q <= wdt_q + {{(`WDT_W-1){1'b0}}, 1'b1};
    end
  end

  // ========================================================
  // reset pin and fixed outputs
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_reset_o        <= 1'b0;
      ext_reset_pin_oe_o <= 1'b0;
      vector_addr_o      <= `IRQ_VECTOR;
    end else begin
      // watchdog restart stays internal, the pin is never pulled
      wdt_reset_o        <= run_tmo;
      ext_reset_pin_oe_o <= 1'b0;
      vector_addr_o      <= `IRQ_VECTOR;
    end
  end

  // ========================================================
  // power state machine and watchdog
  // the oscillator stand-in keeps sys_clk_i alive; wdt models its own rc clock
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q            <= ST_RUN;
      osc_cnt_q          <= 8'h00;
      wake_irq_q         <= 1'b0;
      vec_pend_q         <= 1'b0;
      osc_drive_en_o     <= 1'b1;
      core_hold_o        <= 1'b0;
      prefetch_o         <= 1'b0;
      prefetch_addr_o    <= 13'h0000;
      vector_o           <= 1'b0;
    end else begin
      prefetch_o         <= 1'b0;
      vector_o           <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (do_sleep) begin
            state_q         <= ST_SLEEP;
            osc_drive_en_o  <= 1'b0;
            core_hold_o     <= 1'b1;
            prefetch_o      <= 1'b1;
            prefetch_addr_o <= pc_i + 13'h0001;
          end else if (do_nop) begin
            prefetch_o      <= 1'b1;
            prefetch_addr_o <= pc_i + 13'h0001;
          end
        end
        ST_SLEEP: begin
          if (irq_pend || wdt_to) begin
            state_q        <= ST_OSC;
            osc_drive_en_o <= 1'b1;
            osc_cnt_q      <= `OSC_START_CYC;
            wake_irq_q     <= irq_pend;
          end
        end
        ST_OSC: begin
          if (osc_cnt_q != 8'h00)
            osc_cnt_q <= osc_cnt_q - 8'h01;
          else if (osc_ready_i) begin
            state_q     <= ST_POST;
            core_hold_o <= 1'b0;
            vec_pend_q  <= wake_irq_q && core_irq_q[`CIC_GIE];
          end
        end
        ST_POST: begin
          // one cycle for the prefetched instruction
          state_q    <= ST_RUN;
          vector_o   <= vec_pend_q;
          vec_pend_q <= 1'b0;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

endmodule // sleep_wake_controller

`default_nettype wire

/* File: test/sleep_wake_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_defs.vh"
// ========
// sleep and wake port checks
module sleep_wake_checker (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [12:0] pc_i,
  input wire logic        osc_ready_i,
  input wire logic [7:0]  port_out_o,
  input wire logic [7:0]  port_oe_o,
  input wire logic        osc_drive_en_o,
  input wire logic        core_hold_o,
  input wire logic        prefetch_o,
  input wire logic [12:0] prefetch_addr_o,
  input wire logic        vector_o,
  input wire logic [12:0] vector_addr_o,
  input wire logic        ext_reset_pin_oe_o,
  input wire logic        powerdown_flag_n_o,
  input wire logic        timeout_flag_n_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_enter;
    $rose(core_hold_o) |-> !osc_drive_en_o && !powerdown_flag_n_o && timeout_flag_n_o;
  endproperty
  a_enter: assert property (p_enter) else $error("entry outputs");
  // freeze lands one cycle after the oscillator stops
  property p_hold;
    !$past(osc_drive_en_o) && !osc_drive_en_o |-> $stable(port_out_o) && $stable(port_oe_o);
  endproperty
  a_hold: assert property (p_hold) else $error("port moved");
  property p_pin; !ext_reset_pin_oe_o; endproperty
  a_pin: assert property (p_pin) else $error("pin driven");
  property p_pref; prefetch_o |-> prefetch_addr_o == $past(pc_i) + 13'h1; endproperty
  a_pref: assert property (p_pref) else $error("prefetch");
  property p_vec;
    vector_o |-> vector_addr_o == `IRQ_VECTOR && !$past(core_hold_o) && $past(core_hold_o, 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_resume;
    $fell(core_hold_o) |-> osc_drive_en_o && $past(osc_drive_en_o, 16) && $past(osc_ready_i);
  endproperty
  a_resume: assert property (p_resume) else $error("early resume");
  property p_wake; $rose(osc_drive_en_o) |-> ##[16:40] !core_hold_o; endproperty
  a_wake: assert property (p_wake) else $error("slow wake");
  property p_tmo; $fell(timeout_flag_n_o) |-> $rose(osc_drive_en_o); endproperty
  a_tmo: assert property (p_tmo) else $error("timeout flag");
endmodule // sleep_wake_checker
bind sleep_wake_controller sleep_wake_checker i_sleep_wake_checker (.*);
`default_nettype wire

/* File: test/core_side_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ========
// core side: oscillator warm-up and moving port drive
module core_side_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       osc_drive_en_i,
  output var  logic       osc_ready_o,
  output var  logic [7:0] port_out_o,
  output var  logic [7:0] port_oe_o
);
  logic [2:0] warm_q;
  // ports move every cycle, else a frozen pad looks fine
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warm_q <= 3'h0;
      port_out_o <= 8'h00;
    end else begin
      warm_q <= !osc_drive_en_i ? 3'h0 : warm_q + {2'h0, warm_q != 3'h4};
      port_out_o <= port_out_o + 8'h01;
    end
  end
  assign osc_ready_o = warm_q == 3'h4;
  assign port_oe_o = port_out_o ^ 8'h5a;
endmodule // core_side_model
`default_nettype wire

/* File: test/sleep_wake_controller_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_defs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module sleep_wake_controller_bench;
  logic sys_clk_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic sleep_op_i = 1'h0, ext_pin_irq_i = 1'h0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, port_change_i = 8'h00, periph_irq_i = 8'h00;
  logic [12:0] pc_i = 13'h0000;
  wire [7:0] reg_rdata_o, port_out_i, port_oe_i, port_out_o, port_oe_o;
  wire [12:0] prefetch_addr_o, vector_addr_o;
  wire osc_ready_i, osc_drive_en_o, core_hold_o, prefetch_o, vector_o;
  wire powerdown_flag_n_o, timeout_flag_n_o, irq_o;
  int err_total = 0, n_checks = 0, cyc;
  always #5 sys_clk_i = ~sys_clk_i;
  sleep_wake_controller i_sleep_wake_controller (.*, .wdt_reset_o(), .ext_reset_pin_oe_o());
  core_side_model i_core_side_model (.sys_clk_i, .rst_n_i, .osc_drive_en_i(osc_drive_en_o),
    .osc_ready_o(osc_ready_i), .port_out_o(port_out_i), .port_oe_o(port_oe_i));
  // ========
  // helpers
  task automatic summarize();
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i); reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'h1;
    @(posedge sys_clk_i); reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_i); reg_addr_i <= a; reg_rd_i <= 1'h1;
    @(posedge sys_clk_i); reg_rd_i <= 1'h0;
    @(negedge sys_clk_i); `CHK(reg_rdata_o, e)
  endtask
  task automatic pin();
    @(posedge sys_clk_i); ext_pin_irq_i <= 1'h1;
    @(posedge sys_clk_i); ext_pin_irq_i <= 1'h0;
  endtask
  task automatic sleep(input logic [12:0] p);
    @(posedge sys_clk_i); sleep_op_i <= 1'h1; pc_i <= p;
    @(posedge sys_clk_i); sleep_op_i <= 1'h0;
    @(negedge sys_clk_i); `CHK(prefetch_addr_o, p + 13'h1)
  endtask
  // bounded, a hang ends the run
  task automatic wake(input int lim);
    for (cyc = 0; cyc < lim && core_hold_o !== 1'h0; cyc++) @(negedge sys_clk_i);
    if (cyc == lim) begin err_total++; summarize(); end
  endtask
  // ========
  // scenarios
  task automatic t_nop();
    rd(4'hf, 8'h00);
    rd(`OFF_PERIPH_EN, 8'h00);
    wr(`OFF_CORE_IRQ, 8'h10);
    pin();
    sleep(13'h0040);
    `CHK(core_hold_o, 1'h0)
    rd(`OFF_STATUS, 8'h03);
    wr(`OFF_EVT_MASK, 8'h00);
    repeat (2) @(negedge sys_clk_i); `CHK(irq_o, 1'h0)
    wr(`OFF_EVT_MASK, 8'hff);
    repeat (2) @(negedge sys_clk_i); `CHK(irq_o, 1'h1)
    rd(`OFF_EVT_STATUS, 8'h08);
    repeat (2) @(negedge sys_clk_i); `CHK(irq_o, 1'h0)
  endtask
  task automatic t_irq();
    for (int g = 0; g < 2; g++) begin
      wr(`OFF_CORE_IRQ, {g[0], 7'h10});
      sleep(13'h0123);
      `CHK({core_hold_o, osc_drive_en_o, powerdown_flag_n_o, timeout_flag_n_o}, 4'h9)
      rd(`OFF_STATUS, 8'h0a);
      repeat (20) @(negedge sys_clk_i);
      `CHK(core_hold_o, 1'h1)
      pin();
      wake(40);
      @(negedge sys_clk_i); `CHK(vector_o, g[0])
      rd(`OFF_STATUS, 8'h02);
      rd(`OFF_EVT_STATUS, 8'h03);
    end
  endtask
  // clockless sources only, masked pins and clock-needing peripheral bits never wake
  task automatic t_src();
    wr(`OFF_CORE_IRQ, 8'h48);
    wr(`OFF_PERIPH_EN, 8'hff);
    wr(`OFF_PORT_CHG_MASK, 8'hff);
    rd(`OFF_PORT_CHG_MASK, 8'hf0);
    sleep(13'h0400);
    @(posedge sys_clk_i); periph_irq_i <= 8'h92; port_change_i <= 8'h0f;
    @(posedge sys_clk_i); periph_irq_i <= 8'h00;
    repeat (4) @(negedge sys_clk_i); `CHK(core_hold_o, 1'h1)
    rd(`OFF_PERIPH_FLAGS, 8'h00);
    @(posedge sys_clk_i); periph_irq_i <= 8'h01;
    @(posedge sys_clk_i); periph_irq_i <= 8'h00;
    wake(40);
    @(negedge sys_clk_i); `CHK(vector_o, 1'h0)
    rd(`OFF_PERIPH_FLAGS, 8'h01);
    wr(`OFF_PERIPH_FLAGS, 8'h00);
    rd(`OFF_EVT_STATUS, 8'h03);
    sleep(13'h0500);
    @(posedge sys_clk_i); port_change_i <= 8'h1f;
    wake(40);
    rd(`OFF_CORE_IRQ, 8'h49);
    rd(`OFF_EVT_STATUS, 8'h03);
  endtask
  task automatic t_wdt();
    wr(`OFF_CORE_IRQ, 8'h00);
    wr(`OFF_CTRL, 8'h01);
    sleep(13'h0200);
    rd(`OFF_STATUS, 8'h0e);
    wake(70000);
    `CHK(cyc > 65500 && cyc < 65600, 1'h1)
    `CHK(timeout_flag_n_o, 1'h0)
    @(negedge sys_clk_i); `CHK(vector_o, 1'h0)
    rd(`OFF_EVT_STATUS, 8'h05);
    wr(`OFF_CTRL, 8'h00);
  endtask
  task automatic t_rst();
    sleep(13'h0300);
    @(posedge sys_clk_i); rst_n_i <= 1'h0;
    @(posedge sys_clk_i); rst_n_i <= 1'h1;
    @(negedge sys_clk_i);
    `CHK({core_hold_o, osc_drive_en_o, powerdown_flag_n_o, timeout_flag_n_o}, 4'h7)
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    t_nop();
    t_irq();
    t_src();
    t_wdt();
    t_rst();
    summarize();
  end
endmodule // sleep_wake_controller_bench
`default_nettype wire
